// *** smc_pkg.sv ***
package smc_pkg;
   // Clock plan
   localparam int CLK_HZ = 250_000_000;
   localparam int MCLK_HZ = 8_000_000;
   localparam int MCLK_HALF = CLK_HZ / (2 * MCLK_HZ);
   localparam int LCLK_DIV = 32;
   localparam int LCLK_NS = LCLK_DIV * (1_000_000_000 / MCLK_HZ);
   // Filter delays, counted in master clock ticks
   localparam int FILT_ON_US = 64;
   localparam int FILT_OFF_US = 16;
   localparam int FILT_ON_TICKS = FILT_ON_US * (MCLK_HZ / 1_000_000);
   localparam int FILT_OFF_TICKS = FILT_OFF_US * (MCLK_HZ / 1_000_000);
   // Timers, counted in logic clock ticks
   localparam int TMR_COUNT = 4;
   localparam int TMR_STEPS = 128;
   localparam int TMR_MIN_US = 32;
   localparam int TMR_MAX_MS = 1960;
   localparam int TMR_MIN_TICKS = (TMR_MIN_US * 1000 + LCLK_NS - 1) / LCLK_NS;
   localparam int TMR_MAX_TICKS = TMR_MAX_MS * 1_000_000 / LCLK_NS;
   // Converter path
   localparam int ADC_W = 10;
   localparam int READOUT_W = 12;
   localparam int READOUT_LO_W = 4;
   localparam int ATTEN_MULT = 3;
   // Register offsets
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_WIN = 8'h04;
   localparam logic [7:0] REG_FILT = 8'h08;
   localparam logic [7:0] REG_STAT = 8'h0C;
   localparam logic [7:0] REG_CONV = 8'h10;
   localparam logic [7:0] REG_RDHI = 8'h14;
   localparam logic [7:0] REG_RDLO = 8'h18;
   localparam logic [7:0] REG_TSEL = 8'h1C;
   localparam logic [7:0] REG_TCTRL = 8'h20;
   localparam logic [7:0] REG_GIN = 8'h24;
   // Control register fields and reset value; status and timer control field positions
   localparam int CTRL_OSC = 0;
   localparam int CTRL_PIN = 1;
   localparam int CTRL_DIVOUT = 2;
   localparam int CTRL_ATTEN = 3;
   localparam logic [3:0] CTRL_RST = 4'h1;
   localparam int STAT_SEC_POS = 16;
   localparam int TCTRL_CLR_POS = 4;

   typedef struct packed {
      logic [7:0] addr;
      logic [31:0] wdata;
      logic wr;
      logic rd;
   } smc_bus_t;

   typedef struct packed {
      logic start;
      logic [3:0] chan;
      logic atten;
   } smc_conv_t;

   typedef enum logic {CV_IDLE, CV_BUSY} smc_conv_st_t;
endpackage : smc_pkg

// *** smc_channel.sv ***
`timescale 1ns/1ps
module smc_channel
(
   input wire logic clk,
   input wire logic rst,
   input wire logic upper,
   input wire logic lower,
   input wire logic win_mode,
   input wire logic filt_en,
   input wire logic mtick,
   input wire logic ltick,
   output logic primary,
   output logic secondary
);
   import smc_pkg::*;

   localparam logic [9:0] ON_LAST = 10'(FILT_ON_TICKS - 1);
   localparam logic [9:0] OFF_LAST = 10'(FILT_OFF_TICKS - 1);

   typedef struct packed {
      logic [1:0] stab;
      logic [1:0][9:0] cnt;
      logic pri;
      logic sec;
   } smc_chan_st_t;

   smc_chan_st_t s_r;
   smc_chan_st_t s_nxt;
   logic [1:0] raw;
   logic [9:0] last;

   // Window select, then a stability filter per path, then logic clock retiming
   always_comb
   begin
      s_nxt = s_r;
      raw[0] = win_mode ? (lower & ~upper) : upper;
      raw[1] = lower;
      last = filt_en ? ON_LAST : OFF_LAST;
      if (mtick)
      begin
         for (int i = 0; i < 2; i++)
         begin
            if (raw[i] == s_r.stab[i])
            begin
               s_nxt.cnt[i] = '0;
            end
            else if (s_r.cnt[i] == last)
            begin
               s_nxt.stab[i] = raw[i];
               s_nxt.cnt[i] = '0;
            end
            else
            begin
               s_nxt.cnt[i] = s_r.cnt[i] + 10'h001;
            end
         end
      end
      // Downstream only ever sees changes on the logic clock
      if (ltick)
      begin
         s_nxt.pri = s_r.stab[0];
         s_nxt.sec = s_r.stab[1];
      end
   end

   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
         s_r <= '0;
      else
         s_r <= s_nxt;
   end

   assign primary = s_r.pri;
   assign secondary = s_r.sec;

   AST_SEC_ON_LTICK: assert property (@(posedge clk) disable iff (rst) !ltick |=> $stable(secondary))
      else $error("secondary changed without logic clock");
   AST_FILT_DELAY: assert property (@(posedge clk) disable iff (rst)
      (mtick && raw[1] != s_r.stab[1] && s_r.cnt[1] == last) |=> s_r.stab[1] == $past(raw[1]))
      else $error("filter did not pass after full delay");
   AST_FILT_HOLD: assert property (@(posedge clk) disable iff (rst)
      $changed(s_r.stab[0]) |-> $past(s_r.cnt[0]) == $past(last))
      else $error("filter output changed early");
endmodule : smc_channel

// *** smc_top.sv ***
// What this block does
// - Primary output reports upper comparator or window result, per channel setting.
// - Window result is lower comparator AND NOT upper comparator.
// - Secondary output always reports the lower comparator, even in window mode.
// - Filter enabled: comparator result delayed 64 us.
// - Filter disabled: comparator result still delayed 16 us.
// - Filter stage always synchronises results to the logic clock.
// - Comparator status of every channel readable over the register port.
// - Host may request a conversion any time; result latched into readout.
// - Attenuation picks divide-by-3 (0-6 V) or divide-by-1 (0-2 V).
// - With attenuation set, raw 10-bit result times three, stored as 12 bits.
// - Readout split into upper 8 and lower 4 bits, 2 mV per count.
// - Divide-by-32 prescaler makes 250 kHz logic clock from 8 MHz master clock.
// - Master clock paces comparator sampling and filters.
// - General inputs registered on master clock, comparators on logic clock.
// - Logic state advances on the common logic clock only.
// - Standalone, master and slave clock modes select source and pin drive.
// - Logic clock driven on divided clock pin only when its switch closed.
// - Four timers on logic clock, 32 us to 1.96 s in 128 steps.
//
// Local design decisions: the address map and the address-and-strobe port.
`timescale 1ns/1ps
module smc_top
#(
   parameter int N_CH = 10,
   parameter int TMR_MAX = smc_pkg::TMR_MAX_TICKS
)
(
   input wire logic clk,
   input wire logic rst,
   input wire smc_pkg::smc_bus_t bus,
   output logic [31:0] rdata,
   input wire logic [N_CH-1:0] upper_comparator_out,
   input wire logic [N_CH-1:0] lower_comparator_out,
   input wire logic [3:0] gen_in,
   input wire logic mclk_pin_in,
   output logic mclk_pin_out,
   output logic mclk_pin_oe,
   output logic divided_clock_pin_out,
   output logic divided_clock_pin_oe,
   output smc_pkg::smc_conv_t converter_input_select,
   input wire logic conv_done,
   input wire logic [smc_pkg::ADC_W-1:0] conv_data,
   output logic [N_CH-1:0] primary_out,
   output logic [N_CH-1:0] secondary_out,
   output logic [3:0] gen_in_reg,
   output logic [smc_pkg::TMR_COUNT-1:0] timer_done
);
   import smc_pkg::*;

   localparam int HW = $clog2(MCLK_HALF);
   localparam int PW = $clog2(LCLK_DIV);
   localparam int SW = $clog2(TMR_STEPS);
   localparam int TW = $clog2(TMR_MAX + 1);
   localparam logic [HW-1:0] HALF_LAST = HW'(MCLK_HALF - 1);
   localparam logic [PW-1:0] PRE_LAST = PW'(LCLK_DIV - 1);

   typedef struct packed {
      logic [3:0] ctrl;
      logic [N_CH-1:0] win;
      logic [N_CH-1:0] filt;
      logic [HW-1:0] half;
      logic ph;
      logic pin_q;
      logic mtick;
      logic [PW-1:0] pre;
      logic ltick;
      logic [3:0] gin;
      smc_conv_st_t cst;
      smc_conv_t conv;
      logic [READOUT_W-1:0] readout;
      logic [TMR_COUNT-1:0][SW-1:0] tsel;
      logic [TMR_COUNT-1:0][TW-1:0] tcnt;
      logic [TMR_COUNT-1:0] trun;
      logic [TMR_COUNT-1:0] tdone;
      logic [31:0] rdata;
      logic mclk_oe;
      logic dclk_oe;
   } smc_top_st_t;

   smc_top_st_t s_r;
   smc_top_st_t s_nxt;
   logic [N_CH-1:0] pri_w;
   logic [N_CH-1:0] sec_w;
   logic ext_mode;
   logic int_edge;
   logic ext_edge;
   logic wr_conv;
   logic wr_tctrl;

   // Timeout in logic ticks: mantissa times base, scaled by four per exponent step
   function automatic logic [TW-1:0] smc_ticks(input logic [SW-1:0] sel);
      logic [31:0] t;
      t = ((32'(sel[3:0]) + 32'h1) * 32'(TMR_MIN_TICKS)) << (2 * sel[SW-1:4]);
      if (t > 32'(TMR_MAX))
         t = 32'(TMR_MAX);
      return TW'(t);
   endfunction : smc_ticks

   // One monitor slice per channel
   for (genvar g = 0; g < N_CH; g++)
   begin : g_ch
      smc_channel u_ch
      (
         .clk(clk),
         .rst(rst),
         .upper(upper_comparator_out[g]),
         .lower(lower_comparator_out[g]),
         .win_mode(s_r.win[g]),
         .filt_en(s_r.filt[g]),
         .mtick(s_r.mtick),
         .ltick(s_r.ltick),
         .primary(pri_w[g]),
         .secondary(sec_w[g])
      );
   end

   // Write strobes that several sections look at
   assign wr_conv = bus.wr && bus.addr == REG_CONV;
   assign wr_tctrl = bus.wr && bus.addr == REG_TCTRL;

   // Next-state logic for clocks, registers, converter and timers
   always_comb
   begin
      s_nxt = s_r;

      // Master clock: internal divider or rising edge on the clock pin
      ext_mode = !s_r.ctrl[CTRL_OSC] && s_r.ctrl[CTRL_PIN];
      int_edge = (s_r.half == HALF_LAST) && !s_r.ph;
      ext_edge = mclk_pin_in && !s_r.pin_q;
      s_nxt.pin_q = mclk_pin_in;
      if (s_r.half == HALF_LAST)
      begin
         s_nxt.half = '0;
         s_nxt.ph = ~s_r.ph;
      end
      else
      begin
         s_nxt.half = s_r.half + HW'(1);
      end
      s_nxt.mtick = ext_mode ? ext_edge : int_edge;
      s_nxt.mclk_oe = s_r.ctrl[CTRL_OSC] && s_r.ctrl[CTRL_PIN];
      s_nxt.dclk_oe = s_r.ctrl[CTRL_DIVOUT];

      // Prescaler: one logic tick per 32 master ticks
      s_nxt.ltick = 1'b0;
      if (s_r.mtick)
      begin
         s_nxt.pre = s_r.pre + PW'(1);
         s_nxt.ltick = (s_r.pre == PRE_LAST);
         s_nxt.gin = gen_in;
      end

      // Register writes
      if (bus.wr)
      begin
         if (bus.addr == REG_CTRL)
            s_nxt.ctrl = bus.wdata[3:0];
         else if (bus.addr == REG_WIN)
            s_nxt.win = bus.wdata[N_CH-1:0];
         else if (bus.addr == REG_FILT)
            s_nxt.filt = bus.wdata[N_CH-1:0];
         else if (bus.addr == REG_TSEL)
            s_nxt.tsel = bus.wdata[TMR_COUNT*SW-1:0];
      end

      // Converter: latch the result, scaled by the attenuator setting
      s_nxt.conv.start = 1'b0;
      if (s_r.cst == CV_BUSY && conv_done)
      begin
         if (s_r.conv.atten)
            s_nxt.readout = READOUT_W'(conv_data) * READOUT_W'(ATTEN_MULT);
         else
            s_nxt.readout = READOUT_W'(conv_data);
         s_nxt.cst = CV_IDLE;
      end
      // A new request is always taken, even mid-conversion; the old one is dropped
      if (wr_conv)
      begin
         s_nxt.conv.chan = bus.wdata[3:0];
         s_nxt.conv.atten = s_r.ctrl[CTRL_ATTEN];
         s_nxt.conv.start = 1'b1;
         s_nxt.cst = CV_BUSY;
      end

      // Timers: clear first so an expiry in the same cycle still sets done
      for (int i = 0; i < TMR_COUNT; i++)
      begin
         if (wr_tctrl && bus.wdata[TCTRL_CLR_POS + i])
            s_nxt.tdone[i] = 1'b0;
         if (s_r.ltick && s_r.trun[i])
         begin
            if (s_r.tcnt[i] == TW'(1))
            begin
               s_nxt.tcnt[i] = '0;
               s_nxt.trun[i] = 1'b0;
               s_nxt.tdone[i] = 1'b1;
            end
            else
            begin
               s_nxt.tcnt[i] = s_r.tcnt[i] - TW'(1);
            end
         end
         if (wr_tctrl && bus.wdata[i])
         begin
            s_nxt.tcnt[i] = smc_ticks(s_r.tsel[i]);
            s_nxt.trun[i] = 1'b1;
         end
      end

      // Read data stand for one cycle only, zero otherwise
      s_nxt.rdata = '0;
      if (bus.rd)
      begin
         if (bus.addr == REG_CTRL)
            s_nxt.rdata = 32'(s_r.ctrl);
         else if (bus.addr == REG_WIN)
            s_nxt.rdata = 32'(s_r.win);
         else if (bus.addr == REG_FILT)
            s_nxt.rdata = 32'(s_r.filt);
         else if (bus.addr == REG_STAT)
            s_nxt.rdata = 32'(pri_w) | (32'(sec_w) << STAT_SEC_POS);
         else if (bus.addr == REG_CONV)
            s_nxt.rdata = 32'({s_r.cst == CV_BUSY, s_r.conv.chan});
         else if (bus.addr == REG_RDHI)
            s_nxt.rdata = 32'(s_r.readout[READOUT_W-1:READOUT_LO_W]);
         else if (bus.addr == REG_RDLO)
            s_nxt.rdata = 32'(s_r.readout[READOUT_LO_W-1:0]);
         else if (bus.addr == REG_TSEL)
            s_nxt.rdata = 32'(s_r.tsel);
         else if (bus.addr == REG_TCTRL)
            s_nxt.rdata = 32'({s_r.tdone, s_r.trun});
         else if (bus.addr == REG_GIN)
            s_nxt.rdata = 32'(s_r.gin);
      end
   end

   // Everything clears at reset; clock mode comes up standalone
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         s_r <= '0;
         s_r.ctrl <= CTRL_RST;
      end
      else
      begin
         s_r <= s_nxt;
      end
   end

   // Outputs straight from state flip-flops
   assign rdata = s_r.rdata;
   assign mclk_pin_out = s_r.ph;
   assign mclk_pin_oe = s_r.mclk_oe;
   assign divided_clock_pin_out = s_r.pre[PW-1];
   assign divided_clock_pin_oe = s_r.dclk_oe;
   assign converter_input_select = s_r.conv;
   assign primary_out = pri_w;
   assign secondary_out = sec_w;
   assign gen_in_reg = s_r.gin;
   assign timer_done = s_r.tdone;

   AST_PRESCALE: assert property (@(posedge clk) disable iff (rst)
      s_r.ltick |-> s_r.pre == '0 && $past(s_r.pre) == PRE_LAST)
      else $error("logic tick not at prescaler wrap");
   AST_MASTER_OE: assert property (@(posedge clk) disable iff (rst)
      (s_r.ctrl[CTRL_OSC] && s_r.ctrl[CTRL_PIN]) |=> mclk_pin_oe)
      else $error("master mode does not drive clock pin");
   AST_STANDALONE_TRI: assert property (@(posedge clk) disable iff (rst)
      !s_r.ctrl[CTRL_PIN] |=> !mclk_pin_oe)
      else $error("clock pin driven outside master mode");
   AST_DIVOUT: assert property (@(posedge clk) disable iff (rst)
      !s_r.ctrl[CTRL_DIVOUT] |=> !divided_clock_pin_oe)
      else $error("divided clock driven with switch open");
   AST_ATTEN: assert property (@(posedge clk) disable iff (rst)
      (s_r.cst == CV_BUSY && conv_done && s_r.conv.atten)
      |=> s_r.readout == 12'($past(conv_data)) * 12'h003)
      else $error("attenuated readout not three times raw");
   AST_NO_ATTEN: assert property (@(posedge clk) disable iff (rst)
      (s_r.cst == CV_BUSY && conv_done && !s_r.conv.atten)
      |=> s_r.readout == 12'($past(conv_data)))
      else $error("plain readout differs from raw");
   AST_CONV_START: assert property (@(posedge clk) disable iff (rst)
      wr_conv |=> converter_input_select.start && converter_input_select.chan == $past(bus.wdata[3:0])
      ##1 !converter_input_select.start)
      else $error("conversion request not issued as one pulse");
   AST_TIMER_STEP: assert property (@(posedge clk) disable iff (rst)
      (s_r.trun[0] && !s_r.ltick && !wr_tctrl) |=> s_r.tcnt[0] == $past(s_r.tcnt[0]))
      else $error("timer moved without logic tick");
   AST_STATUS: assert property (@(posedge clk) disable iff (rst)
      (bus.rd && bus.addr == REG_STAT) |=> rdata[N_CH-1:0] == $past(pri_w))
      else $error("status read does not show primary outputs");
   AST_RD_ONE_CYCLE: assert property (@(posedge clk) disable iff (rst)
      !bus.rd |=> rdata == 32'h0000_0000)
      else $error("read data held beyond one cycle");
endmodule : smc_top

// *** smc_conv_model.sv ***
`timescale 1ns/1ps
module smc_conv_model
(
   input wire logic clk,
   input wire logic rst,
   input wire smc_pkg::smc_conv_t sel,
   output logic conv_done,
   output logic [smc_pkg::ADC_W-1:0] conv_data
);
   import smc_pkg::*;
   int cnt_r;
   logic [3:0] ch_r;
   // Odd channels answer slowly, even ones promptly; a new start restarts
   always_ff @(posedge clk or posedge rst)
   begin
      if (rst)
      begin
         cnt_r <= 0;
         ch_r <= 4'h0;
         conv_done <= 1'b0;
         conv_data <= 10'h155;
      end
      else
      begin
         conv_done <= 1'b0;
         conv_data <= ~conv_data; // Data is not held once the pulse ends
         if (sel.start)
         begin
            ch_r <= sel.chan;
            cnt_r <= sel.chan[0] ? 40 : 2;
         end
         else if (cnt_r == 1)
         begin
            conv_done <= 1'b1;
            conv_data <= {ch_r, 6'h3F};
         end
         if (!sel.start && cnt_r != 0)
            cnt_r <= cnt_r - 1;
      end
   end
endmodule : smc_conv_model

// *** test_smc_top.sv ***
`timescale 1ns/1ps
module test_smc_top;
   import smc_pkg::*;
   localparam int MT = 30; // clk cycles per internal master tick: two halves of 15
   logic clk;
   logic rst;
   smc_bus_t bus;
   logic [31:0] rdata;
   logic [9:0] up_cmp;
   logic [9:0] lo_cmp;
   logic [3:0] gen_in;
   logic mclk_in;
   logic mclk_out;
   logic mclk_oe;
   logic dclk_out;
   logic dclk_oe;
   smc_conv_t csel;
   logic conv_done;
   logic [ADC_W-1:0] conv_data;
   logic [9:0] pri;
   logic [9:0] sec;
   logic [3:0] gen_reg;
   logic [3:0] tdone;
   int bad_count;
   int total_checks;
   logic [19:0] old_ps;
   logic [19:0] new_ps;
   logic [11:0] ex;
   logic [3:0] ch;

   smc_top #(.N_CH(10), .TMR_MAX(64)) i_smc_top (.clk(clk), .rst(rst), .bus(bus), .rdata(rdata),
      .upper_comparator_out(up_cmp), .lower_comparator_out(lo_cmp), .gen_in(gen_in),
      .mclk_pin_in(mclk_in), .mclk_pin_out(mclk_out), .mclk_pin_oe(mclk_oe),
      .divided_clock_pin_out(dclk_out), .divided_clock_pin_oe(dclk_oe),
      .converter_input_select(csel), .conv_done(conv_done), .conv_data(conv_data),
      .primary_out(pri), .secondary_out(sec), .gen_in_reg(gen_reg), .timer_done(tdone));

   smc_conv_model i_smc_conv_model (.clk(clk), .rst(rst), .sel(csel), .conv_done(conv_done),
      .conv_data(conv_data));

   // Clocks: 250 MHz system, external master clock of 120 ns period
   initial
   begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   initial
   begin
      mclk_in = 1'b0;
      forever #60 mclk_in = ~mclk_in;
   end

   task automatic print_verdict;
      $display("checks %0d mismatches %0d", total_checks, bad_count);
      if (bad_count == 0 && total_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask : print_verdict

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
      total_checks++;
      if (got !== exp)
      begin
         bad_count++;
         $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
      end
   endtask : chk

   task automatic ticks(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask : ticks

   task automatic wr(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk);
      bus <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
      @(posedge clk);
      bus.wr <= 1'b0;
   endtask : wr

   // Read data stand only in the cycle after the strobe
   task automatic rdchk(input logic [7:0] a, input logic [31:0] exp, input string what);
      @(posedge clk);
      bus <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
      @(posedge clk);
      bus.rd <= 1'b0;
      #1;
      chk(rdata, exp, what);
   endtask : rdchk

   // Cycles between two rising edges of the divided clock, bounded
   task automatic period(input int exp, input string what);
      int n;
      int e;
      int t0;
      logic prev;
      n = 0;
      e = 0;
      t0 = 0;
      prev = 1'b1;
      while (e < 2 && n < 4000)
      begin
         ticks(1);
         n++;
         if (dclk_out === 1'b1 && prev === 1'b0)
         begin
            e++;
            if (e == 1)
               t0 = n;
         end
         prev = dclk_out;
      end
      if (e < 2)
      begin
         bad_count++;
         $display("Error at %0t: no divided clock edge", $time);
         print_verdict();
      end
      chk(n - t0, exp, what);
   endtask : period

   initial
   begin
      rst = 1'b1;
      bus = '0;
      up_cmp = 10'h000;
      lo_cmp = 10'h000;
      gen_in = 4'h0;
      bad_count = 0;
      total_checks = 0;
      repeat (5) @(posedge clk);
      rst <= 1'b0;
      ticks(1);
      chk({31'h0, mclk_oe}, 32'h0, "pin drive after reset");
      rdchk(REG_CTRL, 32'h1, "control after reset");
      rdchk(REG_RDHI, 32'h0, "readout after reset");
      rdchk(8'hFC, 32'h0, "unmapped read");
      $display("test reset done");

      wr(REG_CTRL, 32'h3);
      ticks(2);
      chk({31'h0, mclk_oe}, 32'h1, "master mode drive");
      wr(REG_CTRL, 32'h5);
      ticks(2);
      chk({30'h0, mclk_oe, dclk_oe}, 32'h1, "standalone with divided out");
      period(32 * MT, "internal logic clock period");
      wr(REG_CTRL, 32'h6);
      ticks(2);
      chk({31'h0, mclk_oe}, 32'h0, "slave mode drive");
      period(32 * 30, "slave logic clock period");
      wr(REG_CTRL, 32'h1);
      ticks(2);
      chk({31'h0, dclk_oe}, 32'h0, "divided out off");
      $display("test clocks done");

      // Channel 0 in window mode, channel 1 direct, filters off, then on for both in the last step
      wr(REG_WIN, 32'h1);
      wr(REG_FILT, 32'h0);
      old_ps = 20'h0;
      for (int i = 0; i < 4; i++)
      begin
         @(posedge clk);
         up_cmp <= {8'h00, {2{i == 1}}};
         lo_cmp <= {8'h00, {2{i != 2}}};
         new_ps = {8'h00, {2{i != 2}}, 8'h00, i == 1, i == 0 || i == 3};
         if (i == 3)
            wr(REG_FILT, 32'h3);
         ticks(i == 3 ? 15200 : 3800);
         chk({12'h0, sec, pri}, {12'h0, old_ps}, "output before delay");
         ticks(i == 3 ? 1700 : 1400);
         chk({12'h0, sec, pri}, {12'h0, new_ps}, "outputs after delay");
         rdchk(REG_STAT, {6'h0, new_ps[19:10], 6'h0, new_ps[9:0]}, "status read");
         old_ps = new_ps;
      end
      $display("test monitor done");

      @(posedge clk);
      gen_in <= 4'hA;
      ticks(100);
      chk({28'h0, gen_reg}, 32'hA, "general inputs");
      rdchk(REG_GIN, 32'hA, "general inputs read");
      $display("test inputs done");

      for (int i = 0; i < 2; i++)
      begin
         ch = i ? 4'h9 : 4'h2;
         wr(REG_CTRL, i ? 32'h9 : 32'h1);
         if (i)
            wr(REG_CONV, 32'h3);
         wr(REG_CONV, {28'h0, ch});
         ticks(60);
         ex = {2'b00, ch, 6'h3F} * (i ? 12'h003 : 12'h001);
         rdchk(REG_RDHI, {24'h0, ex[11:4]}, "readout high");
         rdchk(REG_RDLO, {28'h0, ex[3:0]}, "readout low");
      end
      $display("test converter done");

      // Timers 0 and 2 at the shortest step: 8 logic ticks
      wr(REG_TSEL, 32'h0);
      wr(REG_TCTRL, 32'h5);
      rdchk(REG_TCTRL, 32'h5, "timers running");
      ticks(6600);
      chk({28'h0, tdone}, 32'h0, "timers early");
      ticks(1400);
      chk({28'h0, tdone}, 32'h5, "timers expired");
      rdchk(REG_TCTRL, 32'h50, "timer status");
      $display("test timers done");

      @(posedge clk);
      rst <= 1'b1;
      ticks(2);
      rst <= 1'b0;
      ticks(1);
      chk({28'h0, tdone}, 32'h0, "timers after reset");
      rdchk(REG_RDLO, 32'h0, "readout after reset");
      rdchk(REG_CTRL, 32'h1, "control after reset");
      $display("test second reset done");
      print_verdict();
   end
endmodule : test_smc_top
